// ==== shared/pnp_defines.svh ====
`ifndef PNP_DEFINES_SVH
`define PNP_DEFINES_SVH

// ==========================================
// Command codes
`define PNP_CMD_NOP 8'h00
`define PNP_CMD_WR_FUSE 8'h40
`define PNP_CMD_WR_LOCK 8'h20
`define PNP_CMD_WR_FLASH 8'h10
`define PNP_CMD_WR_EE 8'h11
`define PNP_CMD_RD_SIG 8'h08
`define PNP_CMD_RD_FUSE 8'h04
`define PNP_CMD_RD_FLASH 8'h02
`define PNP_CMD_RD_EE 8'h03

// ==========================================
// Action select codes {hi,lo}
`define PNP_ACT_ADDR 2'h0
`define PNP_ACT_DATA 2'h1
`define PNP_ACT_CMD 2'h2

// ==========================================
// Reset values
`define PNP_FUSE_LO_RST 8'hFF
`define PNP_FUSE_HI_RST 8'hFF
`define PNP_FUSE_EXT_RST 8'hFF
`define PNP_LOCK_RST 8'hFF
`define PNP_CAL_RST 8'h80

// ==========================================
// Lock byte fields
`define PNP_LOCK_MODE_ONE 0
`define PNP_LOCK_MODE_TWO 1
`define PNP_LOCK_BOOT_MASK 8'h3C

// ==========================================
// Timing: busy time of a write, in us, and cycles at 10 MHz
`define PNP_CLK_MHZ 10
`define PNP_WRITE_US 3700
`define PNP_WRITE_CYC (`PNP_WRITE_US * `PNP_CLK_MHZ)

`endif

// ==== shared/pnp_pkg.sv ====
package pnp_pkg;
  typedef enum logic [1:0] {
    PNP_DEV_IDLE,
    PNP_DEV_BUSY
  } pnp_dev_state_t;

  typedef enum logic [3:0] {
    PNP_H_IDLE,
    PNP_H_SETUP,
    PNP_H_LOAD_HI,
    PNP_H_LATCH_HI,
    PNP_H_WR_LO,
    PNP_H_WAIT_LO,
    PNP_H_WAIT_RDY,
    PNP_H_RD_ON,
    PNP_H_RD_WAIT,
    PNP_H_RD_TAKE
  } pnp_host_state_t;

  // Host order kinds
  typedef enum logic [2:0] {
    PNP_OP_LOAD,
    PNP_OP_LATCH,
    PNP_OP_COMMIT,
    PNP_OP_READ
  } pnp_op_t;
endpackage

// ==== shared/pnp_if.sv ====
`timescale 1ns/1ps
interface pnp_if;
  logic [7:0] data_host_out;
  logic data_host_oe;
  logic [7:0] data_dev_out;
  logic data_dev_oe;
  logic action_select_hi;
  logic action_select_lo;
  logic byte_select_one;
  logic byte_select_two;
  logic load_strobe;
  logic page_latch_strobe;
  logic commit_strobe_n;
  logic read_drive_n;
  logic op_done_flag;
  // Resolved bus level; pull-up when nobody drives
  logic [7:0] data_bus;
  assign data_bus = data_dev_oe ? data_dev_out : (data_host_oe ? data_host_out : 8'hFF);

  modport device (
    input data_bus, action_select_hi, action_select_lo, byte_select_one, byte_select_two,
    input load_strobe, page_latch_strobe, commit_strobe_n, read_drive_n,
    output data_dev_out, data_dev_oe, op_done_flag
  );
  modport host (
    input data_bus, op_done_flag,
    output data_host_out, data_host_oe, action_select_hi, action_select_lo, byte_select_one,
    output byte_select_two, load_strobe, page_latch_strobe, commit_strobe_n, read_drive_n
  );
endinterface

// ==== core/pnp_device.sv ====
`timescale 1ns/1ps
`include "pnp_defines.svh"
module pnp_device #(
  parameter int FLASH_WORDS = 8192,
  parameter int FLASH_PAGE = 64,
  parameter int EE_BYTES = 512,
  parameter int EE_PAGE = 4,
  parameter int WRITE_CYC = `PNP_WRITE_CYC,
  parameter logic [7:0] SIG0 = 8'h1E, // Arbitrary identification values
  parameter logic [7:0] SIG1 = 8'h55,
  parameter logic [7:0] SIG2 = 8'h0A
) (
  input wire logic clk,
  input wire logic srst,
  pnp_if.device pins
);
  localparam int FAW = $clog2(FLASH_WORDS);
  localparam int FPW = $clog2(FLASH_PAGE);
  localparam int EAW = $clog2(EE_BYTES);
  localparam int EPW = $clog2(EE_PAGE);

  // ==========================================
  // Pin synchronisers
  logic [13:0] s1_q, s2_q;
  logic [13:0] raw;
  assign raw = {pins.data_bus, pins.action_select_hi, pins.action_select_lo, pins.byte_select_one,
                pins.byte_select_two, pins.load_strobe, pins.page_latch_strobe};
  logic rd1_q, rd2_q, wr1_q, wr2_q;
  always_ff @(posedge clk) begin
    s1_q <= raw;
    s2_q <= s1_q;
    rd1_q <= pins.read_drive_n;
    rd2_q <= rd1_q;
    wr1_q <= pins.commit_strobe_n;
    wr2_q <= wr1_q;
  end
  logic [7:0] din;
  logic [1:0] act;
  logic sel_one, sel_two, xs, pl;
  assign din = s2_q[13:6];
  assign act = s2_q[5:4];
  assign sel_one = s2_q[3];
  assign sel_two = s2_q[2];
  assign xs = s2_q[1];
  assign pl = s2_q[0];

  logic xs_q, pl_q, wr_q;
  always_ff @(posedge clk) begin
    xs_q <= srst ? 1'b0 : xs;
    pl_q <= srst ? 1'b0 : pl;
    wr_q <= srst ? 1'b1 : wr2_q;
  end
  logic load_ev, latch_ev, commit_ev;
  assign load_ev = xs & ~xs_q;
  assign latch_ev = pl & ~pl_q;
  assign commit_ev = ~wr2_q & wr_q;

  // ==========================================
  // Command, address and data latches
  pnp_pkg::pnp_dev_state_t st_q;
  logic [7:0] cmd_q, addr_lo_q, addr_hi_q, dlo_q, dhi_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_q <= `PNP_CMD_NOP;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
      dlo_q <= 8'hFF;
      dhi_q <= 8'hFF;
    end else if (load_ev && st_q == pnp_pkg::PNP_DEV_IDLE) begin
      case (act)
        `PNP_ACT_CMD: cmd_q <= din;
        `PNP_ACT_ADDR: begin
          if (sel_one) addr_hi_q <= din;
          else addr_lo_q <= din;
        end
        `PNP_ACT_DATA: begin
          if (sel_one) dhi_q <= din;
          else dlo_q <= din;
        end
        default: ;
      endcase
    end
  end
  logic [15:0] addr;
  assign addr = {addr_hi_q, addr_lo_q};

  // ==========================================
  // Arrays, page buffers, fuses and locks
  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0] ee_mem [EE_BYTES];
  logic [15:0] fbuf [FLASH_PAGE];
  logic [7:0] ebuf [EE_PAGE];
  logic [FLASH_PAGE-1:0] fbuf_v_q;
  logic [EE_PAGE-1:0] ebuf_v_q;
  logic [7:0] fuse_lo_q, fuse_hi_q, fuse_ext_q, lock_q;
  logic [31:0] cnt_q;
  logic [7:0] pend_cmd_q;
  logic [1:0] pend_sel_q;
  logic [15:0] pend_addr_q;
  logic [7:0] pend_data_q;

  // Write controls cleared by NOP command
  logic nop_ev;
  assign nop_ev = load_ev && act == `PNP_ACT_CMD && din == `PNP_CMD_NOP && st_q == pnp_pkg::PNP_DEV_IDLE;

  always_ff @(posedge clk) begin
    if (srst || nop_ev) begin
      fbuf_v_q <= '0;
      ebuf_v_q <= '0;
    end else if (latch_ev && sel_one && st_q == pnp_pkg::PNP_DEV_IDLE) begin
      if (cmd_q == `PNP_CMD_WR_FLASH) begin
        fbuf[addr[FPW-1:0]] <= {dhi_q, dlo_q};
        fbuf_v_q[addr[FPW-1:0]] <= 1'b1;
      end else if (cmd_q == `PNP_CMD_WR_EE) begin
        ebuf[addr[EPW-1:0]] <= dlo_q;
        ebuf_v_q[addr[EPW-1:0]] <= 1'b1;
      end
    end else if (st_q == pnp_pkg::PNP_DEV_BUSY && cnt_q == 32'd1) begin
      // Buffer emptied once its page is committed
      if (pend_cmd_q == `PNP_CMD_WR_FLASH) fbuf_v_q <= '0;
      if (pend_cmd_q == `PNP_CMD_WR_EE) ebuf_v_q <= '0;
    end
  end

  // ==========================================
  // Busy sequencer: capture at commit, apply at end
  logic start_ok;
  assign start_ok = commit_ev && st_q == pnp_pkg::PNP_DEV_IDLE &&
                    (cmd_q == `PNP_CMD_WR_FLASH || cmd_q == `PNP_CMD_WR_FUSE || cmd_q == `PNP_CMD_WR_LOCK ||
                     (cmd_q == `PNP_CMD_WR_EE && !sel_one));
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= pnp_pkg::PNP_DEV_IDLE;
      cnt_q <= 32'd0;
      pend_cmd_q <= `PNP_CMD_NOP;
      pend_sel_q <= 2'b00;
      pend_addr_q <= 16'h0000;
      pend_data_q <= 8'hFF;
    end else begin
      case (st_q)
        pnp_pkg::PNP_DEV_IDLE: begin
          if (start_ok) begin
            st_q <= pnp_pkg::PNP_DEV_BUSY;
            cnt_q <= WRITE_CYC;
            pend_cmd_q <= cmd_q;
            pend_sel_q <= {sel_two, sel_one};
            pend_addr_q <= addr;
            pend_data_q <= dlo_q;
          end
        end
        pnp_pkg::PNP_DEV_BUSY: begin
          cnt_q <= cnt_q - 32'd1;
          if (cnt_q == 32'd1) st_q <= pnp_pkg::PNP_DEV_IDLE;
        end
        default: st_q <= pnp_pkg::PNP_DEV_IDLE;
      endcase
    end
  end

  logic done;
  assign done = st_q == pnp_pkg::PNP_DEV_BUSY && cnt_q == 32'd1;
  logic lvl3;
  assign lvl3 = !lock_q[`PNP_LOCK_MODE_ONE] && !lock_q[`PNP_LOCK_MODE_TWO];
  logic [FAW-1:0] fpage;
  assign fpage = FAW'(pend_addr_q) & ~FAW'(FLASH_PAGE - 1);
  logic [EAW-1:0] epage;
  assign epage = EAW'(pend_addr_q) & ~EAW'(EE_PAGE - 1);

  always_ff @(posedge clk) begin
    if (done && pend_cmd_q == `PNP_CMD_WR_FLASH) begin
      for (int i = 0; i < FLASH_PAGE; i++)
        if (fbuf_v_q[i]) flash_mem[fpage | FAW'(i)] <= fbuf[i];
    end
    if (done && pend_cmd_q == `PNP_CMD_WR_EE) begin
      for (int i = 0; i < EE_PAGE; i++)
        if (ebuf_v_q[i]) ee_mem[epage | EAW'(i)] <= ebuf[i];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fuse_lo_q <= `PNP_FUSE_LO_RST;
      fuse_hi_q <= `PNP_FUSE_HI_RST;
      fuse_ext_q <= `PNP_FUSE_EXT_RST;
      lock_q <= `PNP_LOCK_RST;
    end else if (done && pend_cmd_q == `PNP_CMD_WR_FUSE) begin
      case (pend_sel_q)
        2'b01: fuse_hi_q <= pend_data_q;
        2'b10: fuse_ext_q <= pend_data_q;
        default: fuse_lo_q <= pend_data_q;
      endcase
    end else if (done && pend_cmd_q == `PNP_CMD_WR_LOCK) begin
      // Only ANDing in zeros: no path back to one
      if (lvl3) lock_q <= lock_q & (pend_data_q | `PNP_LOCK_BOOT_MASK);
      else lock_q <= lock_q & pend_data_q;
    end
  end

  // ==========================================
  // Read mux and bus drive
  logic [7:0] rd_d;
  logic [15:0] fword;
  assign fword = flash_mem[FAW'(addr)];
  always_comb begin
    rd_d = 8'hFF;
    case (cmd_q)
      `PNP_CMD_RD_FLASH: rd_d = sel_one ? fword[15:8] : fword[7:0];
      `PNP_CMD_RD_EE: rd_d = ee_mem[EAW'(addr)];
      `PNP_CMD_RD_FUSE: begin
        case ({sel_two, sel_one})
          2'b00: rd_d = fuse_lo_q;
          2'b11: rd_d = fuse_hi_q;
          2'b10: rd_d = fuse_ext_q;
          default: rd_d = lock_q;
        endcase
      end
      `PNP_CMD_RD_SIG: begin
        if (sel_one) rd_d = `PNP_CAL_RST;
        else if (addr_lo_q == 8'h00) rd_d = SIG0;
        else if (addr_lo_q == 8'h01) rd_d = SIG1;
        else if (addr_lo_q == 8'h02) rd_d = SIG2;
        else rd_d = 8'hFF;
      end
      default: rd_d = 8'hFF;
    endcase
  end

  logic [7:0] dout_q;
  logic oe_q, rdy_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      dout_q <= 8'h00;
      oe_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      dout_q <= rd_d;
      oe_q <= !rd2_q;
      rdy_q <= !(start_ok || (st_q == pnp_pkg::PNP_DEV_BUSY && !done));
    end
  end
  assign pins.data_dev_out = dout_q;
  assign pins.data_dev_oe = oe_q;
  assign pins.op_done_flag = rdy_q;
endmodule

// ==== core/pnp_host.sv ====
`timescale 1ns/1ps
`include "pnp_defines.svh"
// ==========================================
// Programmer end: one order at a time from user port
module pnp_host #(
  parameter int PULSE_CYC = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic op_valid,
  input wire logic [2:0] op_kind,
  input wire logic [1:0] op_action,
  input wire logic op_sel_one,
  input wire logic op_sel_two,
  input wire logic [7:0] op_data,
  output logic op_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  pnp_if.host pins
);
  pnp_pkg::pnp_host_state_t st_q;
  logic [7:0] cnt_q, data_q, rdd_q;
  logic [2:0] kind_q;
  logic [1:0] act_q;
  logic sel_one_q, sel_two_q, xs_q, pl_q, wr_q, oe_q, doe_q, rv_q;
  logic rdy1_q, rdy2_q;
  logic [7:0] db1_q, db2_q;

  always_ff @(posedge clk) begin
    rdy1_q <= pins.op_done_flag;
    rdy2_q <= rdy1_q;
    db1_q <= pins.data_bus;
    db2_q <= db1_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= pnp_pkg::PNP_H_IDLE;
      cnt_q <= 8'h00;
      kind_q <= 3'h0;
      act_q <= 2'h0;
      data_q <= 8'h00;
      sel_one_q <= 1'b0;
      sel_two_q <= 1'b0;
      xs_q <= 1'b0;
      pl_q <= 1'b0;
      wr_q <= 1'b1;
      oe_q <= 1'b1;
      doe_q <= 1'b0;
      rv_q <= 1'b0;
      rdd_q <= 8'h00;
    end else begin
      rv_q <= 1'b0;
      case (st_q)
        pnp_pkg::PNP_H_IDLE: begin
          if (op_valid) begin
            kind_q <= op_kind;
            act_q <= op_action;
            sel_one_q <= op_sel_one;
            sel_two_q <= op_sel_two;
            data_q <= op_data;
            doe_q <= op_kind == 3'(pnp_pkg::PNP_OP_LOAD);
            cnt_q <= 8'(PULSE_CYC);
            st_q <= pnp_pkg::PNP_H_SETUP;
          end
        end
        pnp_pkg::PNP_H_SETUP: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            cnt_q <= 8'(PULSE_CYC);
            case (kind_q)
              3'(pnp_pkg::PNP_OP_LOAD): begin xs_q <= 1'b1; st_q <= pnp_pkg::PNP_H_LOAD_HI; end
              3'(pnp_pkg::PNP_OP_LATCH): begin pl_q <= 1'b1; st_q <= pnp_pkg::PNP_H_LATCH_HI; end
              3'(pnp_pkg::PNP_OP_COMMIT): begin wr_q <= 1'b0; st_q <= pnp_pkg::PNP_H_WR_LO; end
              default: begin oe_q <= 1'b0; st_q <= pnp_pkg::PNP_H_RD_ON; end
            endcase
          end
        end
        pnp_pkg::PNP_H_LOAD_HI, pnp_pkg::PNP_H_LATCH_HI: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            xs_q <= 1'b0;
            pl_q <= 1'b0;
            cnt_q <= 8'(PULSE_CYC);
            st_q <= pnp_pkg::PNP_H_WAIT_RDY;
          end
        end
        pnp_pkg::PNP_H_WR_LO: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            wr_q <= 1'b1;
            cnt_q <= 8'(PULSE_CYC);
            st_q <= pnp_pkg::PNP_H_WAIT_LO;
          end
        end
        pnp_pkg::PNP_H_WAIT_LO: begin
          // Give busy time to fall before polling it
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) st_q <= pnp_pkg::PNP_H_WAIT_RDY;
        end
        pnp_pkg::PNP_H_WAIT_RDY: begin
          if (rdy2_q) begin
            doe_q <= 1'b0;
            sel_one_q <= 1'b0;
            sel_two_q <= 1'b0;
            st_q <= pnp_pkg::PNP_H_IDLE;
          end
        end
        pnp_pkg::PNP_H_RD_ON: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) st_q <= pnp_pkg::PNP_H_RD_WAIT;
        end
        pnp_pkg::PNP_H_RD_WAIT: st_q <= pnp_pkg::PNP_H_RD_TAKE;
        pnp_pkg::PNP_H_RD_TAKE: begin
          rdd_q <= db2_q;
          rv_q <= 1'b1;
          oe_q <= 1'b1;
          st_q <= pnp_pkg::PNP_H_IDLE;
        end
        default: st_q <= pnp_pkg::PNP_H_IDLE;
      endcase
    end
  end

  logic rdy_q;
  always_ff @(posedge clk) begin
    rdy_q <= srst ? 1'b0 : (st_q == pnp_pkg::PNP_H_IDLE && !op_valid);
  end
  assign op_ready = rdy_q;
  assign rd_data = rdd_q;
  assign rd_valid = rv_q;
  assign pins.data_host_out = data_q;
  assign pins.data_host_oe = doe_q;
  assign pins.action_select_hi = act_q[1];
  assign pins.action_select_lo = act_q[0];
  assign pins.byte_select_one = sel_one_q;
  assign pins.byte_select_two = sel_two_q;
  assign pins.load_strobe = xs_q;
  assign pins.page_latch_strobe = pl_q;
  assign pins.commit_strobe_n = wr_q;
  assign pins.read_drive_n = oe_q;
endmodule

// ==== verification/pnp_asserts.sv ====
`timescale 1ns/1ps
// ==========================================
// Interface checker for both ends
module pnp_asserts #(
  parameter int WRITE_CYC = 20
) (
  input logic clk,
  input logic srst,
  input logic [7:0] data_host_out,
  input logic data_host_oe,
  input logic data_dev_oe,
  input logic action_select_hi,
  input logic action_select_lo,
  input logic byte_select_one,
  input logic load_strobe,
  input logic page_latch_strobe,
  input logic commit_strobe_n,
  input logic read_drive_n,
  input logic op_done_flag
);
  // Slack covers the two-flop input sync on the device side
  localparam int BUSY_MIN = WRITE_CYC - 10;
  localparam int BUSY_MAX = WRITE_CYC - 4;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_busy;
    !op_done_flag [*8];
  endsequence

  sequence s_strobe_while_busy;
    !op_done_flag && ($rose(load_strobe) || $rose(page_latch_strobe) || $fell(commit_strobe_n));
  endsequence

  AST_RESET_IDLE: assert property ($past(srst) |-> op_done_flag && !data_dev_oe)
    else $error("idle state wrong after reset");
  AST_BUSY_START: assert property ($fell(commit_strobe_n) |-> ##[3:6] !op_done_flag)
    else $error("commit did not raise busy");
  AST_BUSY_LEN: assert property ($fell(op_done_flag) |-> s_busy ##[BUSY_MIN:BUSY_MAX] op_done_flag)
    else $error("busy time wrong");
  AST_HOST_WAITS: assert property (not s_strobe_while_busy)
    else $error("strobe while device busy");
  AST_OE_ON: assert property ($fell(read_drive_n) |-> ##[1:5] data_dev_oe)
    else $error("device did not drive on read");
  AST_OE_OFF: assert property (read_drive_n [*5] |-> !data_dev_oe)
    else $error("device drives without read");
  AST_NO_FIGHT: assert property (!(data_dev_oe && data_host_oe))
    else $error("both ends drive the bus");
  AST_LOAD_STABLE: assert property (load_strobe && $past(load_strobe) |->
    $stable(data_host_out) && $stable(action_select_hi) && $stable(action_select_lo))
    else $error("load inputs moved in pulse");
  AST_LOAD_OE: assert property (load_strobe |-> data_host_oe && read_drive_n)
    else $error("load without host drive");
  AST_LATCH_BS1: assert property (page_latch_strobe |-> byte_select_one)
    else $error("latch without select one");

  // Busy span counted exactly; too long for a repetition
  int busy_cnt_q;
  always_ff @(posedge clk) begin
    busy_cnt_q <= (srst || op_done_flag) ? 0 : busy_cnt_q + 1;
  end
  AST_BUSY_EXACT: assert property ($rose(op_done_flag) |-> busy_cnt_q == WRITE_CYC)
    else $error("busy span not the write time");
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`include "pnp_defines.svh"
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic op_valid = 1'b0;
  logic [2:0] op_kind = 3'h0;
  logic [1:0] op_action = 2'h0;
  logic op_sel_one = 1'b0;
  logic op_sel_two = 1'b0;
  logic [7:0] op_data = 8'h00;
  logic op_ready;
  logic [7:0] rd_data;
  logic rd_valid;
  int fails = 0;
  int n_tests = 0;
  localparam logic [7:0] SIG [3] = '{8'hA1, 8'hB2, 8'hC3}; // Arbitrary identification values

  always #50 clk = ~clk;

  pnp_if u_pnp_if ();
  pnp_device #(.WRITE_CYC(20), .SIG0(SIG[0]), .SIG1(SIG[1]), .SIG2(SIG[2])) u_pnp_device (
    .clk(clk), .srst(srst), .pins(u_pnp_if.device));
  pnp_host u_pnp_host (.clk(clk), .srst(srst), .op_valid(op_valid), .op_kind(op_kind),
    .op_action(op_action), .op_sel_one(op_sel_one), .op_sel_two(op_sel_two), .op_data(op_data),
    .op_ready(op_ready), .rd_data(rd_data), .rd_valid(rd_valid), .pins(u_pnp_if.host));
  pnp_asserts #(.WRITE_CYC(20)) u_pnp_asserts (.clk(clk), .srst(srst),
    .data_host_out(u_pnp_if.data_host_out), .data_host_oe(u_pnp_if.data_host_oe),
    .data_dev_oe(u_pnp_if.data_dev_oe), .action_select_hi(u_pnp_if.action_select_hi),
    .action_select_lo(u_pnp_if.action_select_lo), .byte_select_one(u_pnp_if.byte_select_one),
    .load_strobe(u_pnp_if.load_strobe), .page_latch_strobe(u_pnp_if.page_latch_strobe),
    .commit_strobe_n(u_pnp_if.commit_strobe_n), .read_drive_n(u_pnp_if.read_drive_n),
    .op_done_flag(u_pnp_if.op_done_flag));

  // ==========================================
  // Access tasks
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready sampled at negedge, request launched at posedge and held one edge
  task automatic op(input logic [2:0] k, input logic [1:0] a, input logic b1, input logic b2,
                    input logic [7:0] d);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (op_ready !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      fails++;
      $display("[ERR] %0t host never ready", $time);
    end
    @(posedge clk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_action <= a;
    op_sel_one <= b1;
    op_sel_two <= b2;
    op_data <= d;
    @(posedge clk);
    op_valid <= 1'b0;
  endtask

  task automatic ld(input logic [1:0] a, input logic b1, input logic [7:0] d);
    op(pnp_pkg::PNP_OP_LOAD, a, b1, 1'b0, d);
  endtask

  task automatic cmd(input logic [7:0] c);
    ld(`PNP_ACT_CMD, 1'b0, c);
  endtask

  task automatic commit(input logic b1, input logic b2);
    op(pnp_pkg::PNP_OP_COMMIT, 2'h0, b1, b2, 8'h00);
  endtask

  task automatic latch();
    op(pnp_pkg::PNP_OP_LATCH, 2'h0, 1'b1, 1'b0, 8'h00);
  endtask

  task automatic rd(input logic b1, input logic b2, input logic [7:0] exp);
    int n;
    op(pnp_pkg::PNP_OP_READ, 2'h0, b1, b2, 8'h00);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rd_valid !== 1'b1 && n < 100);
    if (n >= 100) begin
      fails++;
      $display("[ERR] %0t read never answered", $time);
    end
    chk(rd_data, exp);
    repeat (6) @(negedge clk);
    chk({7'h00, u_pnp_if.data_dev_oe}, 8'h00);
  endtask

  task automatic fl_wr(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] w);
    ld(`PNP_ACT_ADDR, 1'b0, lo);
    ld(`PNP_ACT_DATA, 1'b0, w[7:0]);
    ld(`PNP_ACT_DATA, 1'b1, w[15:8]);
    latch();
    ld(`PNP_ACT_ADDR, 1'b1, hi);
    commit(1'b0, 1'b0);
  endtask

  task automatic fl_rd(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] w);
    ld(`PNP_ACT_ADDR, 1'b1, hi);
    ld(`PNP_ACT_ADDR, 1'b0, lo);
    rd(1'b0, 1'b0, w[7:0]);
    rd(1'b1, 1'b0, w[15:8]);
  endtask

  task automatic lock_wr(input logic [7:0] d, input logic [7:0] exp);
    cmd(`PNP_CMD_WR_LOCK);
    ld(`PNP_ACT_DATA, 1'b0, d);
    commit(1'b0, 1'b0);
    cmd(`PNP_CMD_RD_FUSE);
    rd(1'b1, 1'b0, exp);
  endtask

  // ==========================================
  // Tests
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    cmd(`PNP_CMD_RD_FUSE);
    rd(1'b0, 1'b0, `PNP_FUSE_LO_RST);
    rd(1'b1, 1'b1, `PNP_FUSE_HI_RST);
    rd(1'b0, 1'b1, `PNP_FUSE_EXT_RST);
    rd(1'b1, 1'b0, `PNP_LOCK_RST);
    $display("test reset values done");
    cmd(`PNP_CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      ld(`PNP_ACT_ADDR, 1'b0, 8'(i));
      rd(1'b0, 1'b0, SIG[i]);
    end
    ld(`PNP_ACT_ADDR, 1'b0, 8'h00);
    rd(1'b1, 1'b0, `PNP_CAL_RST);
    $display("test identification done");
    cmd(`PNP_CMD_WR_FUSE);
    ld(`PNP_ACT_DATA, 1'b0, 8'hA5);
    commit(1'b0, 1'b0);
    ld(`PNP_ACT_DATA, 1'b0, 8'h3C);
    commit(1'b1, 1'b0);
    ld(`PNP_ACT_DATA, 1'b0, 8'h96);
    commit(1'b0, 1'b1);
    cmd(`PNP_CMD_RD_FUSE);
    rd(1'b0, 1'b0, 8'hA5);
    rd(1'b1, 1'b1, 8'h3C);
    rd(1'b0, 1'b1, 8'h96);
    $display("test fuses done");
    lock_wr(8'hFB, 8'hFB);
    lock_wr(8'hFC, 8'hF8);
    lock_wr(8'hC3, 8'hF8);
    lock_wr(8'hFF, 8'hF8);
    $display("test locks done");
    cmd(`PNP_CMD_WR_FLASH);
    fl_wr(8'h00, 8'h05, 16'h1234);
    fl_wr(8'h01, 8'h05, 16'hABCD);
    cmd(`PNP_CMD_NOP);
    cmd(`PNP_CMD_RD_FLASH);
    fl_rd(8'h00, 8'h05, 16'h1234);
    fl_rd(8'h01, 8'h05, 16'hABCD);
    $display("test flash done");
    cmd(`PNP_CMD_WR_EE);
    ld(`PNP_ACT_ADDR, 1'b1, 8'h00);
    ld(`PNP_ACT_ADDR, 1'b0, 8'h08);
    ld(`PNP_ACT_DATA, 1'b0, 8'h5A);
    latch();
    ld(`PNP_ACT_ADDR, 1'b0, 8'h09);
    ld(`PNP_ACT_DATA, 1'b0, 8'hA6);
    latch();
    commit(1'b0, 1'b0);
    cmd(`PNP_CMD_NOP);
    cmd(`PNP_CMD_RD_EE);
    ld(`PNP_ACT_ADDR, 1'b0, 8'h08);
    rd(1'b0, 1'b0, 8'h5A);
    ld(`PNP_ACT_ADDR, 1'b0, 8'h09);
    rd(1'b0, 1'b0, 8'hA6);
    rd(1'b0, 1'b0, 8'hA6);
    // Byte latched before a no-operation must not reach the page
    cmd(`PNP_CMD_WR_EE);
    ld(`PNP_ACT_ADDR, 1'b0, 8'h08);
    ld(`PNP_ACT_DATA, 1'b0, 8'h33);
    latch();
    cmd(`PNP_CMD_NOP);
    cmd(`PNP_CMD_WR_EE);
    ld(`PNP_ACT_ADDR, 1'b0, 8'h09);
    ld(`PNP_ACT_DATA, 1'b0, 8'hC7);
    latch();
    commit(1'b0, 1'b0);
    cmd(`PNP_CMD_RD_EE);
    ld(`PNP_ACT_ADDR, 1'b0, 8'h08);
    rd(1'b0, 1'b0, 8'h5A);
    ld(`PNP_ACT_ADDR, 1'b0, 8'h09);
    rd(1'b0, 1'b0, 8'hC7);
    $display("test eeprom done");
    wrap_up();
  end

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule
